// ---- core/vsw_ctrl_top.sv ----
// Purpose: control register bank of a four-input video link switch with serial slave access
// Assumes: scl/sda and all pins synchronous to clk; scl well below clk/4
// Notes:   open-drain lines appear as out/oe pairs, oe high while pulling low
// Functional notes
// [R1] channel source 0: select pins choose the input, register field ignored
// [R2] channel source 1: register field 00..11 picks input A..D
// [R3] output control bit 3 picks output enable source: pin or register
// [R4] with register source, enable bit 2 disables at 0, enables at 1
// [R5] output control bit 1 selects lower or higher drive current
// [R6] output control bit 0 switches output termination off or on
// [R7] input control bit 1 selects low or high equalizer boost
// [R8] input control bit 0 selects standard or inverted input polarity
// [R9] termination upper nibble: 0000 automatic, 1111 manual from lower nibble
// [R10] manual termination: lower nibble bit n enables termination on input n
// [R11] buffer register bit 1 disables or enables the display channel buffer
// [R12] buffer register bit 0 disables or enables the consumer control buffer
// [R13] hot-plug pulse duration equals width register times 24 ms step
// [R14] override bit 4 picks automatic pulsing or manual nibble control
// [R15] manual mode: each set nibble bit pulls one hot-plug output low
// [R16] automatic mode: outputs released, pulsed low on every channel change
// [R17] automatic termination: only the selected input is terminated
// [R18] serial slave address is 10010 then two address pins
// [R19] low register reset pin restores all registers to defaults
// [R20] unused bits read zero, ignore writes; written bits hold; side buffer bit 2 drives nothing but is writable and reads back
`timescale 1ns/100ps
`default_nettype none
module vsw_ctrl_top #(
	parameter int unsigned HPD_STEP_CYCLES = vsw_pkg::HPD_STEP_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       register_reset_n,
	input  wire logic [1:0] slave_addr_pins,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic [1:0] input_select_pins,
	input  wire logic       output_enable_pin,
	output logic [1:0]      active_input,
	output logic            output_enable,
	output logic            output_drive_level,
	output logic            output_termination_on,
	output logic            boost_level_select,
	output logic            input_polarity_invert,
	output logic [3:0]      input_termination_on,
	output logic            display_channel_buffer_on,
	output logic            consumer_control_buffer_on,
	output logic [3:0]      hotplug_out,
	output logic [3:0]      hotplug_oe
);
	typedef enum logic [3:0] {
		ST_IDLE, ST_DEVADDR, ST_ACK_DEV, ST_REGADDR, ST_ACK_REG,
		ST_WRITE, ST_ACK_WR, ST_READ, ST_WAIT_MACK, ST_READ_LOAD
	} vsw_state_t;

	vsw_state_t  state_q;
	logic        scl_q;
	logic        sda_q;
	logic [7:0]  shift_q;
	logic [2:0]  bit_cnt_q;
	logic        rw_q;
	logic        ack_on_q;
	logic [7:0]  ptr_q;
	logic        sda_oe_q;

	logic [7:0]  channel_select_ctrl_q;
	logic [7:0]  output_link_ctrl_q;
	logic [7:0]  input_link_ctrl_q;
	logic [7:0]  input_termination_ctrl_q;
	logic [7:0]  side_buffer_enables_q;
	logic [7:0]  hotplug_pulse_width_q;
	logic [7:0]  hotplug_manual_override_q;

	logic [1:0]  active_input_q;
	logic [1:0]  sel_d;
	logic        sel_valid_q;
	logic        chan_change;
	logic        pulse_active;
	logic [3:0]  auto_term;
	logic [7:0]  rd_data;
	logic [7:0]  rx_byte;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_cond;
	logic        stop_cond;
	logic        byte_done;
	logic        wr_fire;
	logic [3:0]  term_mode_field;
	logic [3:0]  termination_manual_mask;
	logic [3:0]  hotplug_manual_mask;
	logic        hotplug_mode_select;
	logic        input_choice_source;

	// bus condition detection on sampled lines
	assign scl_rise   = scl_in & ~scl_q;
	assign scl_fall   = ~scl_in & scl_q;
	assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
	assign stop_cond  = scl_in & scl_q & ~sda_q & sda_in;
	assign rx_byte    = {shift_q[6:0], sda_in};
	assign byte_done  = scl_rise & (bit_cnt_q == vsw_pkg::BIT_CNT_LAST);
	assign wr_fire    = (state_q == ST_WRITE) & byte_done;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	// serial slave protocol engine
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q   <= ST_IDLE;
			shift_q   <= 8'h00;
			bit_cnt_q <= 3'h0;
			rw_q      <= 1'b0;
			ack_on_q  <= 1'b0;
			ptr_q     <= 8'h00;
			sda_oe_q  <= 1'b0;
		end else if (start_cond) begin
			// repeated start may cut in anywhere, even mid-byte
			state_q   <= ST_DEVADDR;
			bit_cnt_q <= 3'h0;
			ack_on_q  <= 1'b0;
			sda_oe_q  <= 1'b0;
		end else if (stop_cond) begin
			state_q  <= ST_IDLE;
			ack_on_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					sda_oe_q <= 1'b0;
				end
				ST_DEVADDR, ST_REGADDR, ST_WRITE: begin
					if (scl_rise) begin
						shift_q   <= rx_byte;
						bit_cnt_q <= bit_cnt_q + 3'h1;
					end
					if (byte_done) begin
						if (state_q == ST_DEVADDR) begin
							if (rx_byte[7:1] == {vsw_pkg::SLAVE_ADDR_HI, slave_addr_pins}) begin // see [R18]
								state_q <= ST_ACK_DEV;
								rw_q    <= rx_byte[0];
							end else begin
								state_q <= ST_IDLE;
							end
						end else if (state_q == ST_REGADDR) begin
							ptr_q   <= rx_byte;
							state_q <= ST_ACK_REG;
						end else begin
							ptr_q   <= ptr_q + 8'h01;
							state_q <= ST_ACK_WR;
						end
					end
				end
				ST_ACK_DEV, ST_ACK_REG, ST_ACK_WR: begin
					if (scl_fall) begin
						if (!ack_on_q) begin
							ack_on_q <= 1'b1;
							sda_oe_q <= 1'b1;
						end else begin
							ack_on_q  <= 1'b0;
							bit_cnt_q <= 3'h0;
							if (state_q == ST_ACK_DEV && rw_q) begin
								state_q  <= ST_READ;
								shift_q  <= rd_data;
								sda_oe_q <= ~rd_data[7];
							end else begin
								state_q  <= (state_q == ST_ACK_DEV) ? ST_REGADDR : ST_WRITE;
								sda_oe_q <= 1'b0;
							end
						end
					end
				end
				ST_READ: begin
					if (scl_fall) begin
						if (bit_cnt_q == vsw_pkg::BIT_CNT_LAST) begin
							sda_oe_q <= 1'b0;
							state_q  <= ST_WAIT_MACK;
							ptr_q    <= ptr_q + 8'h01;
						end else begin
							sda_oe_q  <= ~shift_q[6];
							shift_q   <= {shift_q[6:0], 1'b0};
							bit_cnt_q <= bit_cnt_q + 3'h1;
						end
					end
				end
				ST_WAIT_MACK: begin
					// master nack ends the read; bus waits for stop or start
					if (scl_rise) begin
						state_q <= sda_in ? ST_IDLE : ST_READ_LOAD;
					end
				end
				ST_READ_LOAD: begin
					if (scl_fall) begin
						state_q   <= ST_READ;
						bit_cnt_q <= 3'h0;
						shift_q   <= rd_data;
						sda_oe_q  <= ~rd_data[7];
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe  = sda_oe_q;

	// register file; the reset pin synchronously reloads the reset values
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			channel_select_ctrl_q     <= vsw_pkg::RST_CHANNEL_SELECT_CTRL;
			output_link_ctrl_q        <= vsw_pkg::RST_OUTPUT_LINK_CTRL;
			input_link_ctrl_q         <= vsw_pkg::RST_INPUT_LINK_CTRL;
			input_termination_ctrl_q  <= vsw_pkg::RST_INPUT_TERMINATION_CTRL;
			side_buffer_enables_q     <= vsw_pkg::RST_SIDE_BUFFER_ENABLES;
			hotplug_pulse_width_q     <= vsw_pkg::RST_HOTPLUG_PULSE_WIDTH;
			hotplug_manual_override_q <= vsw_pkg::RST_HOTPLUG_MANUAL_OVERRIDE;
		end else if (!register_reset_n) begin // see [R19]
			channel_select_ctrl_q     <= vsw_pkg::RST_CHANNEL_SELECT_CTRL;
			output_link_ctrl_q        <= vsw_pkg::RST_OUTPUT_LINK_CTRL;
			input_link_ctrl_q         <= vsw_pkg::RST_INPUT_LINK_CTRL;
			input_termination_ctrl_q  <= vsw_pkg::RST_INPUT_TERMINATION_CTRL;
			side_buffer_enables_q     <= vsw_pkg::RST_SIDE_BUFFER_ENABLES;
			hotplug_pulse_width_q     <= vsw_pkg::RST_HOTPLUG_PULSE_WIDTH;
			hotplug_manual_override_q <= vsw_pkg::RST_HOTPLUG_MANUAL_OVERRIDE;
		end else if (wr_fire) begin
			// unmapped offsets and unused bits drop the write
			unique case (ptr_q)
				vsw_pkg::ADDR_CHANNEL_SELECT_CTRL:
					channel_select_ctrl_q <= rx_byte & vsw_pkg::MASK_CHANNEL_SELECT_CTRL; // see [R20]
				vsw_pkg::ADDR_OUTPUT_LINK_CTRL:
					output_link_ctrl_q <= rx_byte & vsw_pkg::MASK_OUTPUT_LINK_CTRL; // see [R20]
				vsw_pkg::ADDR_INPUT_LINK_CTRL:
					input_link_ctrl_q <= rx_byte & vsw_pkg::MASK_INPUT_LINK_CTRL; // see [R20]
				vsw_pkg::ADDR_INPUT_TERMINATION_CTRL:
					input_termination_ctrl_q <= rx_byte & vsw_pkg::MASK_INPUT_TERMINATION_CTRL;
				vsw_pkg::ADDR_SIDE_BUFFER_ENABLES:
					side_buffer_enables_q <= rx_byte & vsw_pkg::MASK_SIDE_BUFFER_ENABLES; // see [R20]
				vsw_pkg::ADDR_HOTPLUG_PULSE_WIDTH:
					hotplug_pulse_width_q <= rx_byte & vsw_pkg::MASK_HOTPLUG_PULSE_WIDTH;
				vsw_pkg::ADDR_HOTPLUG_MANUAL_OVERRIDE:
					hotplug_manual_override_q <= rx_byte & vsw_pkg::MASK_HOTPLUG_MANUAL_OVERRIDE; // see [R20]
				default: begin
				end
			endcase
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		unique case (ptr_q)
			vsw_pkg::ADDR_CHANNEL_SELECT_CTRL:     rd_data = channel_select_ctrl_q;
			vsw_pkg::ADDR_OUTPUT_LINK_CTRL:        rd_data = output_link_ctrl_q;
			vsw_pkg::ADDR_INPUT_LINK_CTRL:         rd_data = input_link_ctrl_q;
			vsw_pkg::ADDR_INPUT_TERMINATION_CTRL:  rd_data = input_termination_ctrl_q;
			vsw_pkg::ADDR_SIDE_BUFFER_ENABLES:     rd_data = side_buffer_enables_q;
			vsw_pkg::ADDR_HOTPLUG_PULSE_WIDTH:     rd_data = hotplug_pulse_width_q;
			vsw_pkg::ADDR_HOTPLUG_MANUAL_OVERRIDE: rd_data = hotplug_manual_override_q;
			default:                               rd_data = 8'h00;
		endcase
	end

	assign input_choice_source     = channel_select_ctrl_q[vsw_pkg::BIT_INPUT_CHOICE_SOURCE];
	assign term_mode_field         = input_termination_ctrl_q[7:4];
	assign termination_manual_mask = input_termination_ctrl_q[3:0];
	assign hotplug_manual_mask     = hotplug_manual_override_q[3:0];
	assign hotplug_mode_select     = hotplug_manual_override_q[vsw_pkg::BIT_HOTPLUG_MODE_SELECT];

	// input selection: pins or register field
	assign sel_d = input_choice_source ? channel_select_ctrl_q[1:0] // see [R2]
	                                   : input_select_pins; // see [R1]

	// first cycle after reset is not a channel change
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			active_input_q <= 2'h0;
			sel_valid_q    <= 1'b0;
		end else begin
			active_input_q <= sel_d;
			sel_valid_q    <= 1'b1;
		end
	end

	assign chan_change = sel_valid_q & (sel_d != active_input_q); // see [R16]

	vsw_onehot_dec #(
		.W (2)
	) u_term_dec (
		.idx    (active_input_q),
		.onehot (auto_term)
	);

	vsw_hpd_timer #(
		.STEP_CYCLES (HPD_STEP_CYCLES)
	) u_hpd_timer (
		.clk     (clk),
		.rst     (rst),
		.trigger (chan_change & ~hotplug_mode_select),
		.width   (hotplug_pulse_width_q),
		.active  (pulse_active)
	);

	// registered control outputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			output_enable              <= 1'b0;
			output_drive_level         <= 1'b0;
			output_termination_on      <= 1'b0;
			boost_level_select         <= 1'b0;
			input_polarity_invert      <= 1'b0;
			input_termination_on       <= 4'h0;
			display_channel_buffer_on  <= 1'b0;
			consumer_control_buffer_on <= 1'b0;
			hotplug_oe                 <= 4'h0;
		end else begin
			if (output_link_ctrl_q[vsw_pkg::BIT_OUTPUT_ENABLE_SOURCE]) begin // see [R3]
				output_enable <= output_link_ctrl_q[vsw_pkg::BIT_OUTPUT_ENABLE]; // see [R4]
			end else begin
				output_enable <= output_enable_pin;
			end
			output_drive_level         <= output_link_ctrl_q[vsw_pkg::BIT_OUTPUT_DRIVE_LEVEL]; // see [R5]
			output_termination_on      <= output_link_ctrl_q[vsw_pkg::BIT_OUTPUT_TERMINATION_ON]; // see [R6]
			boost_level_select         <= input_link_ctrl_q[vsw_pkg::BIT_BOOST_LEVEL_SELECT]; // see [R7]
			input_polarity_invert      <= input_link_ctrl_q[vsw_pkg::BIT_INPUT_POLARITY_INVERT]; // see [R8]
			// any mode code other than all ones falls back to automatic
			if (term_mode_field == vsw_pkg::TERM_MODE_MANUAL) begin // see [R9]
				input_termination_on <= termination_manual_mask; // see [R10]
			end else begin
				input_termination_on <= auto_term; // see [R17]
			end
			display_channel_buffer_on  <= side_buffer_enables_q[vsw_pkg::BIT_DISPLAY_CHANNEL_BUFFER_ON]; // see [R11]
			consumer_control_buffer_on <= side_buffer_enables_q[vsw_pkg::BIT_CONSUMER_CONTROL_BUFFER_ON]; // see [R12]
			if (hotplug_mode_select) begin // see [R14]
				hotplug_oe <= hotplug_manual_mask; // see [R15]
			end else begin
				hotplug_oe <= {4{pulse_active}}; // see [R16]
			end
		end
	end

	assign active_input = active_input_q;
	assign hotplug_out  = 4'h0;
endmodule
`default_nettype wire

// ---- core/vsw_pkg.sv ----
// Purpose: shared constants for the video switch control register bank
// Assumes: 40 MHz core clock, byte-wide registers reached over a two-wire serial slave
// Notes:   offsets, reset values and field positions live here only
package vsw_pkg;
	// clock and hot-plug pulse timing
	localparam int unsigned CLK_KHZ         = 40000;
	localparam int unsigned HPD_STEP_MS     = 24;
	localparam int unsigned HPD_STEP_CYCLES = HPD_STEP_MS * CLK_KHZ;

	// serial slave address: five fixed upper bits, two from pins
	localparam logic [4:0] SLAVE_ADDR_HI = 5'h12;

	// register offsets
	localparam logic [7:0] ADDR_CHANNEL_SELECT_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_OUTPUT_LINK_CTRL        = 8'h01;
	localparam logic [7:0] ADDR_INPUT_LINK_CTRL         = 8'h02;
	localparam logic [7:0] ADDR_INPUT_TERMINATION_CTRL  = 8'h03;
	localparam logic [7:0] ADDR_SIDE_BUFFER_ENABLES     = 8'h04;
	localparam logic [7:0] ADDR_HOTPLUG_PULSE_WIDTH     = 8'h05;
	localparam logic [7:0] ADDR_HOTPLUG_MANUAL_OVERRIDE = 8'h06;

	// reset values
	localparam logic [7:0] RST_CHANNEL_SELECT_CTRL     = 8'h00;
	localparam logic [7:0] RST_OUTPUT_LINK_CTRL        = 8'h07;
	localparam logic [7:0] RST_INPUT_LINK_CTRL         = 8'h02;
	localparam logic [7:0] RST_INPUT_TERMINATION_CTRL  = 8'h0f;
	localparam logic [7:0] RST_SIDE_BUFFER_ENABLES     = 8'h07;
	localparam logic [7:0] RST_HOTPLUG_PULSE_WIDTH     = 8'h05;
	localparam logic [7:0] RST_HOTPLUG_MANUAL_OVERRIDE = 8'h00;

	// implemented bits of each register
	localparam logic [7:0] MASK_CHANNEL_SELECT_CTRL     = 8'h07;
	localparam logic [7:0] MASK_OUTPUT_LINK_CTRL        = 8'h0f;
	localparam logic [7:0] MASK_INPUT_LINK_CTRL         = 8'h03;
	localparam logic [7:0] MASK_INPUT_TERMINATION_CTRL  = 8'hff;
	localparam logic [7:0] MASK_SIDE_BUFFER_ENABLES     = 8'h07;
	localparam logic [7:0] MASK_HOTPLUG_PULSE_WIDTH     = 8'hff;
	localparam logic [7:0] MASK_HOTPLUG_MANUAL_OVERRIDE = 8'h1f;

	// field positions
	localparam int unsigned BIT_INPUT_CHOICE_SOURCE        = 2;
	localparam int unsigned BIT_OUTPUT_ENABLE_SOURCE       = 3;
	localparam int unsigned BIT_OUTPUT_ENABLE              = 2;
	localparam int unsigned BIT_OUTPUT_DRIVE_LEVEL         = 1;
	localparam int unsigned BIT_OUTPUT_TERMINATION_ON      = 0;
	localparam int unsigned BIT_BOOST_LEVEL_SELECT         = 1;
	localparam int unsigned BIT_INPUT_POLARITY_INVERT      = 0;
	localparam int unsigned BIT_DISPLAY_CHANNEL_BUFFER_ON  = 1;
	localparam int unsigned BIT_CONSUMER_CONTROL_BUFFER_ON = 0;
	localparam int unsigned BIT_HOTPLUG_MODE_SELECT        = 4;

	localparam logic [3:0] TERM_MODE_MANUAL = 4'hf;
	localparam logic [2:0] BIT_CNT_LAST     = 3'h7;
endpackage

// ---- core/vsw_onehot_dec.sv ----
// Purpose: binary index to one-hot decoder
// Assumes: out width is two to the power of the index width
// Notes:   purely combinational
`timescale 1ns/100ps
`default_nettype none
module vsw_onehot_dec #(
	parameter int unsigned W = 2
) (
	input  wire logic [W-1:0]      idx,
	output logic      [(1<<W)-1:0] onehot
);
	always_comb begin
		onehot = '0;
		onehot[idx] = 1'b1;
	end
endmodule
`default_nettype wire

// ---- core/vsw_hpd_timer.sv ----
// Purpose: hot-plug low pulse of width units times a fixed step
// Assumes: trigger is a one-cycle pulse
// Notes:   a new trigger restarts the pulse; width zero gives no pulse
`timescale 1ns/100ps
`default_nettype none
module vsw_hpd_timer #(
	parameter int unsigned STEP_CYCLES = vsw_pkg::HPD_STEP_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       trigger,
	input  wire logic [7:0] width,
	output logic            active
);
	localparam int unsigned CW = $clog2(STEP_CYCLES + 1);
	localparam logic [CW-1:0] STEP_LAST = CW'(STEP_CYCLES - 1);

	logic [CW-1:0] step_q;
	logic [7:0]    units_q;

	// pulse length is width times the step count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			step_q  <= '0;
			units_q <= 8'h00;
		end else if (trigger) begin
			step_q  <= '0;
			units_q <= width; // see [R13]
		end else if (units_q != 8'h00) begin
			if (step_q == STEP_LAST) begin
				step_q  <= '0;
				units_q <= units_q - 8'h01;
			end else begin
				step_q <= step_q + CW'(1);
			end
		end
	end

	assign active = (units_q != 8'h00);
endmodule
`default_nettype wire

// ---- bench/vsw_ctrl_checker.sv ----
// Purpose: port-level checks for the video switch control register bank
// Assumes: serial clock stays high and low for at least three clocks each
// Notes:   bound to the top module; sees its ports only
`timescale 1ns/100ps
`default_nettype none
module vsw_ctrl_checker #(
	parameter int unsigned HPD_STEP_CYCLES = vsw_pkg::HPD_STEP_CYCLES
) (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       register_reset_n,
	input wire logic       scl_in,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic       output_drive_level,
	input wire logic       output_termination_on,
	input wire logic       boost_level_select,
	input wire logic       input_polarity_invert,
	input wire logic       display_channel_buffer_on,
	input wire logic       consumer_control_buffer_on,
	input wire logic [3:0] hotplug_out,
	input wire logic [3:0] hotplug_oe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_defaults;
		output_drive_level && output_termination_on && boost_level_select && !input_polarity_invert
			&& display_channel_buffer_on && consumer_control_buffer_on;
	endsequence

	sequence s_all_low_rise;
		$rose(hotplug_oe == 4'hf);
	endsequence

	a_sda_open_drain: assert property (sda_out == 1'b0)
		else $error("data line driven high");
	a_hpd_open_drain: assert property (hotplug_out == 4'h0)
		else $error("hot-plug line driven high");
	a_ack_after_fall: assert property ($changed(sda_oe) |-> !$past(scl_in)
		&& ($past(scl_in, 2) || $past(scl_in, 3)))
		else $error("data line moved away from clock fall");
	a_oe_hold_bit: assert property ($changed(sda_oe) |=> $stable(sda_oe) [*4])
		else $error("data line bit too short");
	a_reset_defaults: assert property ($fell(rst) |=> s_defaults)
		else $error("control outputs not at defaults after reset");
	a_regreset_defaults: assert property (!register_reset_n |-> ##2 s_defaults)
		else $error("control outputs not restored by register reset");
	a_hpd_pulse_min: assert property (s_all_low_rise |-> (hotplug_oe == 4'hf) [*8])
		else $error("hot-plug pulse too short");
	a_manual_after_write: assert property ($changed(hotplug_oe) && hotplug_oe != 4'hf
		&& $past(hotplug_oe) != 4'hf |-> $past(scl_in))
		else $error("partial hot-plug pattern without a write");
endmodule

bind vsw_ctrl_top vsw_ctrl_checker #(.HPD_STEP_CYCLES(HPD_STEP_CYCLES)) chk_u (
	.clk, .rst, .register_reset_n, .scl_in, .sda_out, .sda_oe, .output_drive_level, .output_termination_on,
	.boost_level_select, .input_polarity_invert, .display_channel_buffer_on, .consumer_control_buffer_on,
	.hotplug_out, .hotplug_oe
);
`default_nettype wire

// ---- bench/vsw_i2c_master.sv ----
// Purpose: serial bus master standing in for the host controller
// Assumes: device pulls data low through sda_oe; pull-up otherwise
// Notes:   clock stands high between frames; each bit holds the clock low for twice hp clocks and high for hp clocks
`timescale 1ns/100ps
`default_nettype none
module vsw_i2c_master (
	input  wire logic clk,
	input  wire logic sda_oe,
	output logic      scl,
	output logic      sda
);
	logic sda_q  = 1'b1;
	logic rd_ack = 1'b0;
	int   hp     = 4;

	// wired-and with the pull-up: released line reads high
	assign sda = sda_q & ~sda_oe;
	initial scl = 1'b1;

	task automatic w;
		repeat (hp) @(posedge clk);
		#1;
	endtask

	task automatic start;
		sda_q = 1'b1;
		w();
		scl = 1'b1;
		w();
		sda_q = 1'b0;
		w();
		scl = 1'b0;
		w();
	endtask

	task automatic stop;
		sda_q = 1'b0;
		w();
		scl = 1'b1;
		w();
		sda_q = 1'b1;
		w();
	endtask

	// ninth bit released, so reads end in nack, unless rd_ack asks for a read ack
	task automatic xb(input logic [7:0] d, output logic [7:0] r, output logic nak);
		for (int i = 7; i >= -1; i--) begin
			sda_q = (i < 0) ? ~rd_ack : d[i];
			w();
			scl = 1'b1;
			w();
			if (i < 0)
				nak = sda;
			else
				r[i] = sda;
			scl = 1'b0;
			w();
		end
	endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Purpose: self-checking bench for the video switch control register bank
// Assumes: master model stands in for the host controller
// Notes:   hot-plug step shortened to ten clocks to keep the run short
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam int STEP = 10;
	typedef struct {int s; logic [15:0] e;} vsw_note_t;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       register_reset_n = 1'b1;
	logic [1:0] slave_addr_pins = 2'h0;
	logic [1:0] input_select_pins = 2'h0;
	logic       output_enable_pin = 1'b0;
	wire logic  scl;
	wire logic  sda;
	logic       sda_out, sda_oe, output_enable, output_drive_level, output_termination_on, boost_level_select;
	logic       input_polarity_invert, display_channel_buffer_on, consumer_control_buffer_on, ak;
	logic [1:0] active_input;
	logic [3:0] input_termination_on, hotplug_out, hotplug_oe;
	logic [7:0] r, v, u;
	logic [15:0] got;
	int         n, fail_count = 0, check_count = 0;
	vsw_note_t  q [$];
	vsw_note_t  nt;
	wire logic [6:0] sa = {vsw_pkg::SLAVE_ADDR_HI, slave_addr_pins};
	string      nm [5] = '{"read_data", "active_input", "input_termination_on", "hotplug_oe", "flags"};
	logic [3:0] tm [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hf, 4'h0};
	logic [7:0] hw [2] = '{8'h01, 8'hff};
	logic [7:0] rv [7] = '{vsw_pkg::RST_CHANNEL_SELECT_CTRL, vsw_pkg::RST_OUTPUT_LINK_CTRL,
		vsw_pkg::RST_INPUT_LINK_CTRL, vsw_pkg::RST_INPUT_TERMINATION_CTRL, vsw_pkg::RST_SIDE_BUFFER_ENABLES,
		vsw_pkg::RST_HOTPLUG_PULSE_WIDTH, vsw_pkg::RST_HOTPLUG_MANUAL_OVERRIDE};
	logic [7:0] mk [7] = '{vsw_pkg::MASK_CHANNEL_SELECT_CTRL, vsw_pkg::MASK_OUTPUT_LINK_CTRL,
		vsw_pkg::MASK_INPUT_LINK_CTRL, vsw_pkg::MASK_INPUT_TERMINATION_CTRL, vsw_pkg::MASK_SIDE_BUFFER_ENABLES,
		vsw_pkg::MASK_HOTPLUG_PULSE_WIDTH, vsw_pkg::MASK_HOTPLUG_MANUAL_OVERRIDE};

	always #12.5 clk = ~clk;

	vsw_i2c_master m_u (.clk, .sda_oe, .scl, .sda);
	vsw_ctrl_top #(.HPD_STEP_CYCLES(STEP)) dut_u (.clk, .rst, .register_reset_n, .slave_addr_pins,
		.scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .input_select_pins, .output_enable_pin, .active_input,
		.output_enable, .output_drive_level, .output_termination_on, .boost_level_select, .input_polarity_invert,
		.input_termination_on, .display_channel_buffer_on, .consumer_control_buffer_on, .hotplug_out, .hotplug_oe);

	function automatic logic [15:0] obs(input int s);
		case (s)
			1: return {14'h0, active_input};
			2: return {12'h0, input_termination_on};
			3: return {12'h0, hotplug_oe};
			4: return {9'h0, output_enable, output_drive_level, output_termination_on, boost_level_select,
				input_polarity_invert, display_channel_buffer_on, consumer_control_buffer_on};
			default: return got;
		endcase
	endfunction

	// compared half a cycle later, once the launching edge has settled
	always @(negedge clk) begin
		while (q.size() > 0) begin
			nt = q.pop_front();
			check_count++;
			if (obs(nt.s) !== nt.e) begin
				fail_count++;
				$display("MISMATCH %s exp %h got %h", nm[nt.s], nt.e, obs(nt.s));
			end
		end
	end

	task automatic chk(input int s, input logic [15:0] e);
		q.push_back('{s, e});
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		m_u.start();
		m_u.xb({sa, 1'b0}, r, ak);
		m_u.xb(a, r, ak);
		m_u.xb(d, r, ak);
		m_u.stop();
	endtask

	task automatic rd(input logic [7:0] a);
		m_u.start();
		m_u.xb({sa, 1'b0}, r, ak);
		m_u.xb(a, r, ak);
		m_u.start();
		m_u.xb({sa, 1'b1}, r, ak);
		m_u.xb(8'hff, r, ak);
		m_u.stop();
		got = {8'h0, r};
	endtask

	task automatic final_report;
		if (fail_count == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		void'($urandom(32'hf14c));
		slave_addr_pins = 2'($urandom);
		cyc(2);
		rst = 1'b0;
		cyc(1);
		for (int i = 0; i < 7; i++) begin
			rd(8'(i));
			chk(0, rv[i]);
			wr(8'(i), 8'hff);
			rd(8'(i));
			chk(0, mk[i]);
		end
		wr(8'h07, 8'h5a);
		rd(8'h07);
		chk(0, 16'h0);
		for (int i = 0; i < 7; i++) begin
			v = 8'($urandom);
			wr(8'(i), v);
			rd(8'(i));
			chk(0, v & mk[i]);
		end
		// burst write, then burst read with a master ack between the bytes
		v = 8'($urandom);
		u = 8'($urandom);
		m_u.start();
		m_u.xb({sa, 1'b0}, r, ak);
		m_u.xb(8'h05, r, ak);
		m_u.xb(v, r, ak);
		m_u.xb(u, r, ak);
		m_u.start();
		m_u.xb({sa, 1'b0}, r, ak);
		m_u.xb(8'h05, r, ak);
		m_u.start();
		m_u.xb({sa, 1'b1}, r, ak);
		m_u.rd_ack = 1'b1;
		m_u.xb(8'hff, r, ak);
		got = {8'h0, r};
		chk(0, {8'h0, v});
		m_u.rd_ack = 1'b0;
		m_u.xb(8'hff, r, ak);
		m_u.stop();
		got = {8'h0, r};
		chk(0, {8'h0, u & vsw_pkg::MASK_HOTPLUG_MANUAL_OVERRIDE});
		// manual partial pattern must be gone before the register reset
		wr(8'h06, 8'h00);
		register_reset_n = 1'b0;
		cyc(2);
		register_reset_n = 1'b1;
		cyc(100);
		m_u.hp = 9;
		for (int i = 0; i < 7; i++) begin
			rd(8'(i));
			chk(0, rv[i]);
		end
		m_u.hp = 4;
		for (int k = 0; k < 4; k++) begin
			input_select_pins = 2'(k);
			cyc(3);
			chk(1, 16'(k));
			chk(2, 16'(1 << k));
		end
		for (int k = 0; k < 4; k++) begin
			wr(8'h00, 8'h04 | 8'(k));
			input_select_pins = 2'($urandom);
			cyc(3);
			chk(1, 16'(k));
			chk(2, 16'(1 << k));
		end
		foreach (tm[j]) begin
			wr(8'h03, {4'hf, tm[j]});
			chk(2, 16'(tm[j]));
			wr(8'h06, {4'h1, tm[j]});
			chk(3, 16'(tm[j]));
		end
		wr(8'h03, 8'h70);
		chk(2, 16'h8);
		wr(8'h06, 8'h00);
		for (int i = 0; i < 8; i++) begin
			v = 8'($urandom);
			u = 8'($urandom);
			output_enable_pin = 1'($urandom);
			wr(8'h01, v);
			wr(8'h02, u);
			wr(8'h04, u >> 4);
			chk(4, {9'h0, v[3] ? v[2] : output_enable_pin, v[1], v[0], u[1], u[0], u[5],
				u[4]});
		end
		m_u.hp = 3;
		for (int j = 0; j < 4; j++) begin
			m_u.start();
			m_u.xb({vsw_pkg::SLAVE_ADDR_HI, 2'(j), 1'b0}, r, ak);
			m_u.stop();
			got = {15'h0, ak};
			chk(0, {15'h0, 2'(j) != slave_addr_pins});
		end
		m_u.hp = 4;
		wr(8'h00, 8'h00);
		foreach (hw[j]) begin
			wr(8'h05, hw[j]);
			input_select_pins = input_select_pins + 2'h1;
			n = 0;
			for (int t = 0; t < 20 && hotplug_oe !== 4'hf; t++)
				cyc(1);
			if (hotplug_oe !== 4'hf) begin
				fail_count++;
				$display("MISMATCH hotplug_oe exp f got %h", hotplug_oe);
				final_report();
			end
			while (hotplug_oe === 4'hf && n < 3000) begin
				cyc(1);
				n++;
			end
			got = 16'(n);
			chk(0, 16'(hw[j]) * 16'(STEP));
		end
		wr(8'h05, 8'h00);
		input_select_pins = input_select_pins + 2'h1;
		cyc(8);
		chk(3, 16'h0);
		cyc(2);
		final_report();
	end
endmodule
`default_nettype wire
